// ### core/xmb_bus.sv
// External program and data memory bus with boot-time code source selection
//
// Overview of operation
// - High address port carries upper address bytes
// - Port two written one: weak pull-up
// - Select high: internal code below F800h
// - Sample access select only at reset end
// - Program strobe high during internal execution
// - Program strobe low at reset: download
// - Latch strobe captures low and page bytes
// - Latch strobe once per external bus cycle, data cycles included
// - Power control bit four stops latch strobe
// - Address/data port open-drain when idle
// - Bus cycles drive strong ones
// - Internal fetches above F7FFh return no-op
// - 56 Kbytes internal code rewritable at runtime
// - Download mode writes internal code space
// - Write strobe latches data for writes
// - Read strobe enables data for reads
`include "xmb_cfg.svh"
`default_nettype none
module xmb_bus (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        external_access_select,
  input  wire logic        program_store_strobe_in,
  input  wire logic [7:0]  power_control_register,
  input  wire logic [7:0]  port2_latch,
  input  wire logic [7:0]  port0_latch,
  input  wire logic        code_req,
  input  wire logic [15:0] code_addr,
  input  wire logic [7:0]  int_code_data,
  input  wire logic        data_req,
  input  wire logic        data_write,
  input  wire logic        data_wide,
  input  wire logic [23:0] data_addr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        flash_wr_req,
  input  wire logic [15:0] flash_wr_addr,
  input  wire logic [7:0]  address_data_port_in,
  output logic [7:0]       address_data_port_out,
  output logic [7:0]       address_data_port_oe_n,
  output logic [7:0]       high_address_port,
  output logic [7:0]       high_address_pullup_weak,
  output logic             program_store_strobe,
  output logic             address_latch_strobe,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic             code_ext,
  output logic             download_mode,
  output logic             flash_wr_ok,
  output logic [7:0]       fetch_data,
  output logic             fetch_valid,
  output logic [7:0]       read_data,
  output logic             data_done
);
  logic [1:0]          sel_sync;
  logic [1:0]          ps_sync;
  logic                boot_pending;
  logic [2:0]          phase;
  xmb_pkg::xmb_cycle_e cycle;
  logic [23:0]         addr;
  logic [7:0]          wdata;
  logic                ale_off;

  // ****************************************
  // Phase decoding
  // ****************************************
  function automatic logic last_phase(input logic [2:0] ph);
    return ph == `XMB_PHASES - 3'h1;
  endfunction : last_phase

  // ****************************************
  // Boot pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk) begin   // No reset: pins settle while reset is held
    sel_sync <= {sel_sync[0], external_access_select};
    ps_sync  <= {ps_sync[0], program_store_strobe_in};
  end

  // ****************************************
  // Boot pin sampling
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_pending  <= 1'b1;
      code_ext      <= 1'b0;
      download_mode <= 1'b0;
    end else if (boot_pending) begin
      boot_pending  <= 1'b0;
      code_ext      <= ~sel_sync[1];
      download_mode <= ~ps_sync[1];
    end
  end

  // ****************************************
  // Flash write window
  // ****************************************
  assign flash_wr_ok = flash_wr_req & ((download_mode & (flash_wr_addr <= `XMB_INT_CODE_TOP)) |
                       (flash_wr_addr <= `XMB_RUNTIME_TOP));

  // ****************************************
  // Internal and external fetch results
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fetch_data  <= 8'h00;
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= 1'b0;
      if (code_req && !code_ext && cycle == xmb_pkg::XMB_IDLE && !boot_pending) begin
        fetch_valid <= 1'b1;
        fetch_data  <= (code_addr > `XMB_INT_CODE_TOP) ? `XMB_NOP_OPCODE : int_code_data;
      end else if (cycle == xmb_pkg::XMB_CODE && last_phase(phase)) begin
        fetch_valid <= 1'b1;
        fetch_data  <= address_data_port_in;
      end
    end
  end

  // ****************************************
  // External bus cycle sequencer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cycle <= xmb_pkg::XMB_IDLE;
      phase <= 3'h0;
      addr  <= 24'h000000;
      wdata <= 8'h00;
    end else if (cycle == xmb_pkg::XMB_IDLE) begin
      phase <= 3'h0;
      if (!boot_pending && data_req) begin
        cycle <= data_write ? xmb_pkg::XMB_WR : xmb_pkg::XMB_RD;
        addr  <= data_wide ? data_addr : {8'h00, data_addr[15:0]};
        wdata <= data_wdata;
      end else if (!boot_pending && code_req && code_ext) begin
        cycle <= xmb_pkg::XMB_CODE;
        addr  <= {8'h00, code_addr};
      end
    end else if (last_phase(phase)) begin
      cycle <= xmb_pkg::XMB_IDLE;
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      read_data <= 8'h00;
      data_done <= 1'b0;
    end else begin
      data_done <= (cycle == xmb_pkg::XMB_RD || cycle == xmb_pkg::XMB_WR) && last_phase(phase);
      if (cycle == xmb_pkg::XMB_RD && last_phase(phase)) begin
        read_data <= address_data_port_in;
      end
    end
  end

  // ****************************************
  // Latch strobe disable
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ale_off <= 1'b0;
    end else begin
      ale_off <= power_control_register[`XMB_ALE_OFF_BIT];
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      address_latch_strobe     <= 1'b0;
      program_store_strobe     <= 1'b1;
      read_strobe_n            <= 1'b1;
      write_strobe_n           <= 1'b1;
      address_data_port_out    <= 8'hFF;
      address_data_port_oe_n   <= 8'hFF;
      high_address_port        <= 8'hFF;
      high_address_pullup_weak <= 8'hFF;
    end else begin
      address_latch_strobe <= 1'b0;
      program_store_strobe <= 1'b1;
      read_strobe_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      if (cycle == xmb_pkg::XMB_IDLE) begin
        address_data_port_out    <= port0_latch;
        address_data_port_oe_n   <= port0_latch;
        high_address_port        <= port2_latch;
        high_address_pullup_weak <= port2_latch;
      end else begin
        high_address_pullup_weak <= 8'h00;
        high_address_port        <= (phase <= `XMB_ADDR_PHASE && cycle != xmb_pkg::XMB_CODE) ?
                                    addr[23:16] : addr[15:8];
        address_latch_strobe     <= ~ale_off && phase == `XMB_ALE_PHASE;
        if (phase <= `XMB_ADDR_PHASE) begin
          address_data_port_out  <= addr[7:0];
          address_data_port_oe_n <= 8'h00;
        end else if (cycle == xmb_pkg::XMB_WR) begin
          address_data_port_out  <= wdata;
          address_data_port_oe_n <= 8'h00;
          write_strobe_n         <= last_phase(phase) ? 1'b1 : 1'b0;
        end else begin
          address_data_port_oe_n <= 8'hFF;
          if (cycle == xmb_pkg::XMB_RD) begin
            read_strobe_n <= 1'b0;
          end else begin
            program_store_strobe <= 1'b0;
          end
        end
      end
    end
  end
endmodule : xmb_bus
`default_nettype wire

// ### core/xmb_cfg.svh
// Constants for the external memory bus and boot select block
`ifndef XMB_CFG_SVH
`define XMB_CFG_SVH
`define XMB_PHASES        3'h6
`define XMB_ALE_PHASE     3'h0
`define XMB_ADDR_PHASE    3'h1
`define XMB_INT_CODE_TOP  16'hF7FF
`define XMB_NOP_OPCODE    8'h00
`define XMB_ALE_OFF_BIT   4
`define XMB_RUNTIME_TOP   16'hDFFF
`define XMB_CLK_MHZ       10
`endif

// ### core/xmb_pkg.sv
// Types for the external memory bus and boot select block
`default_nettype none
package xmb_pkg;
  typedef enum logic [1:0] {XMB_IDLE, XMB_CODE, XMB_RD, XMB_WR} xmb_cycle_e;
endpackage : xmb_pkg
`default_nettype wire

// ### bench/xmb_bus_sva.sv
// Assertion checker for the external memory bus strobes and boot capture
`default_nettype none
module xmb_bus_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] power_control_register,
  input wire logic [7:0] address_data_port_oe_n,
  input wire logic       program_store_strobe,
  input wire logic       address_latch_strobe,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       code_ext,
  input wire logic       download_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ale_off_a: assert property (
    $past(power_control_register[4], 1) && $past(power_control_register[4], 2) |-> !address_latch_strobe)
    else $error("latch strobe while disabled");
  prog_len_a: assert property (
    $fell(program_store_strobe) |-> !program_store_strobe [*4] ##1 program_store_strobe)
    else $error("program strobe length");
  wr_len_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
    else $error("write strobe length");
  int_prog_a: assert property (!code_ext |-> program_store_strobe)
    else $error("program strobe in internal mode");
  ale_addr_a: assert property (address_latch_strobe |-> address_data_port_oe_n == 8'h00)
    else $error("address not driven at latch");
  rd_float_a: assert property (!read_strobe_n |-> address_data_port_oe_n == 8'hFF)
    else $error("port driven during read");
  wr_drive_a: assert property (!write_strobe_n |-> address_data_port_oe_n == 8'h00)
    else $error("port not driven during write");
  ale_data_a: assert property (!read_strobe_n || !write_strobe_n |-> !address_latch_strobe)
    else $error("latch strobe in data phase");
  boot_hold_a: assert property (
    !$past(rst, 1) && !$past(rst, 2) |-> $stable(code_ext) && $stable(download_mode))
    else $error("boot choice changed");
endmodule : xmb_bus_sva
bind xmb_bus xmb_bus_sva u_xmb_bus_sva (.core_clk, .rst, .power_control_register, .address_data_port_oe_n,
  .program_store_strobe, .address_latch_strobe, .read_strobe_n, .write_strobe_n, .code_ext, .download_mode);
`default_nettype wire

// ### bench/xmb_ext_mem.sv
// External program and data memory with address latch
`default_nettype none
module xmb_ext_mem (
  input  wire logic [7:0] address_data_port_out,
  input  wire logic [7:0] address_data_port_oe_n,
  input  wire logic [7:0] high_address_port,
  input  wire logic       core_clk,
  input  wire logic       program_store_strobe,
  input  wire logic       address_latch_strobe,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  output logic [7:0]      address_data_port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lo, page, drv;
  logic [7:0] mem [256];
  always @(negedge address_latch_strobe) begin
    lo = address_data_port_out;
    page = high_address_port;
  end
  always @(posedge core_clk) if (!write_strobe_n) mem[lo] <= address_data_port_out;
  always_comb begin
    drv = 8'hFF; // Pull-up on released lines
    if (!program_store_strobe) drv = lo ^ page ^ 8'hA5;
    if (!read_strobe_n) drv = mem[lo] ^ page;
    address_data_port_in = (address_data_port_out & ~address_data_port_oe_n) | (drv & address_data_port_oe_n);
  end
endmodule : xmb_ext_mem
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the external memory bus and boot select block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, external_access_select = 1'b1, program_store_strobe_in = 1'b1;
  logic code_req, data_req, data_write, data_wide, flash_wr_req, program_store_strobe, address_latch_strobe;
  logic read_strobe_n, write_strobe_n, code_ext, download_mode, flash_wr_ok, fetch_valid, data_done;
  logic [7:0] power_control_register, port2_latch, port0_latch, int_code_data, data_wdata, address_data_port_in;
  logic [7:0] address_data_port_out, address_data_port_oe_n, high_address_port, high_address_pullup_weak;
  logic [7:0] fetch_data, read_data, d, pg;
  logic [15:0] code_addr, flash_wr_addr, a;
  logic [23:0] data_addr;
  logic [31:0] seed = 32'h0000132A;
  logic [8:0] e;
  logic [8:0] q [$];
  int n_mismatch = 0, checks = 0, cyc = 0;
  xmb_bus u_xmb_bus (.*);
  xmb_ext_mem u_xmb_ext_mem (.*);
  always #50 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic boot(input logic sel, input logic ps);
    rst <= 1'b1;
    external_access_select <= sel; // Held constant outside reset
    program_store_strobe_in <= ps;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({6'h00, code_ext, download_mode}, {6'h00, !sel, !ps});
  endtask : boot
  task automatic fl(input logic [15:0] ad, input logic ex);
    flash_wr_req <= 1'b1;
    flash_wr_addr <= ad;
    @(posedge core_clk);
    chk({7'h00, flash_wr_ok}, {7'h00, ex});
  endtask : fl
  // Kind 0 code fetch, 1 data read, 2 data write
  task automatic op(input int kind, input logic [23:0] ad, input logic [7:0] wd, input logic [8:0] ex);
    q.push_back(ex);
    code_req <= kind == 0;
    data_req <= kind != 0;
    data_write <= kind == 2;
    data_wide <= ad[23:16] != 8'h00;
    code_addr <= ad[15:0];
    data_addr <= ad;
    data_wdata <= wd;
    int_code_data <= wd;
    @(posedge core_clk);
    code_req <= 1'b0;
    data_req <= 1'b0;
    for (int i = 0; i < 12 && fetch_valid !== 1'b1 && data_done !== 1'b1; i++) @(posedge core_clk);
    @(posedge core_clk);
  endtask : op
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
    if (fetch_valid === 1'b1 || data_done === 1'b1) begin
      e = q.pop_front();
      if (e[8] === 1'b0) chk(fetch_valid ? fetch_data : read_data, e[7:0]);
    end
  end
  initial begin
    {code_req, data_req, data_write, data_wide, flash_wr_req} = 5'h00;
    {code_addr, flash_wr_addr, data_addr, data_wdata, int_code_data} = 72'h0;
    power_control_register = 8'h00;
    port2_latch = 8'(rnd());
    port0_latch = 8'(rnd());
    boot(1'b1, 1'b1);
    chk(high_address_pullup_weak, port2_latch);
    chk(address_data_port_oe_n, port0_latch);
    fl(16'hDFFF, 1'b1);
    fl(16'hE000, 1'b0);
    fl(16'hF7FF, 1'b0);
    for (int k = 0; k < 24; k++) begin
      a = k < 4 ? 16'hF7FE + 16'(k) : 16'(rnd());
      d = 8'(rnd());
      op(0, {8'h00, a}, d, {1'b0, a <= 16'hF7FF ? d : 8'h00});
    end
    boot(1'b0, 1'b0);
    fl(16'hF7FF, 1'b1);
    fl(16'hF800, 1'b0);
    for (int k = 0; k < 24; k++) begin
      a = 16'(rnd());
      d = 8'(rnd());
      pg = k[0] ? 8'(rnd()) : 8'h00;
      power_control_register <= {3'h0, k > 19, 4'h0};
      op(0, {8'h00, a}, d, {k > 19, a[7:0] ^ a[15:8] ^ 8'hA5});
      op(2, {pg, a}, d, 9'h100);
      op(1, {pg, a}, d, {k > 19, d ^ pg});
    end
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
